// ---- sfr_responder.sv ----
// SPI slave frame responder with identification register.
// Takes 32-bit commands MSB first and answers the previous one on SO.
// Registers behind the link: the id word at address zero and a small store.
// Assumes SCK, SI and chip select come asynchronously from an SPI master,
// and that SCK is slow enough (period >= 4 clk) to be edge-sampled.
// Assumes the watchdog fault input is already in the clk domain.
// The SO pad is outside: so_out is driven onto the pin while so_oe is high.
`timescale 1ns/1ps
`include "sfr_cfg.svh"
////////////////////////////////////////////////////////////////////////
module sfr_responder #(
	parameter logic [7:0] MAKER   = `SFR_MAKER_CODE, // Arbitrary value
	parameter logic [7:0] VERSION = `SFR_VER_CODE,   // Arbitrary value
	parameter int         DEPTH   = `SFR_REG_DEPTH
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic chip_select_n,
	input  wire logic clock_watchdog_fault,
	output logic      so_out,
	output logic      so_oe,
	output logic      frame_error
);
	import sfr_pkg::*;
	localparam int CW = $clog2(`SFR_FRAME_BITS + 1) + 1;
	sfr_pins_t             pins_s;
	logic                  sck_q;
	logic                  cs_q;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  cs_rise;
	logic                  cs_fall;
	logic [31:0]           rx_q;
	logic [31:0]           tx_q;
	logic [CW-1:0]         cnt_q;
	logic                  wds_q;
	logic                  first_q;
	logic                  bad_q;
	logic                  we;
	logic [`SFR_ADDR_W-1:0] addr_q;
	logic [`SFR_ADDR_W-1:0] mem_addr;
	logic [23:0]           mem_rdata;
	logic [31:0]           resp;
	sfr_cmd_t              cmd;
	////////////////////////////////////////////////////////////////////
	// Pin synchronisation; all pin logic reads only the second stage.
	// Reset levels match the idle pins (clock low, data low, select high),
	// so no false edge is seen when reset is released.
	sfr_sync #(.W(3), .INIT(3'h1)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({sck, si, chip_select_n}),
		.q     (pins_s)
	);
	// Edge history of synchronised SCK and chip select
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			sck_q <= pins_s.sck;
			cs_q  <= pins_s.cs_n;
		end
	end
	// SCK edges count only inside a frame; a free-running or glitching
	// clock while deselected cannot disturb the shifters
	assign sck_rise = pins_s.sck & ~sck_q & ~pins_s.cs_n;
	assign sck_fall = ~pins_s.sck & sck_q & ~pins_s.cs_n;
	assign cs_fall = ~pins_s.cs_n & cs_q;
	assign cs_rise = pins_s.cs_n & ~cs_q;
	////////////////////////////////////////////////////////////////////
	// Identification word built from constants and sticky status
	function automatic logic [31:0] id_word(input logic clock_watchdog_status);
		logic [31:0] w;
		w = 32'h00000000;
		w[`SFR_MAKER_HI:`SFR_MAKER_LO] = MAKER;
		w[`SFR_VER_HI:`SFR_VER_LO]     = VERSION;
		w[`SFR_WDS_BIT] = clock_watchdog_status;
		return w;
	endfunction : id_word
	// a frame counts only with exactly 32 clocked bits
	function automatic logic frame_whole(input logic [CW-1:0] n);
		return n == CW'(`SFR_FRAME_BITS);
	endfunction : frame_whole
	// data rows start at address one; zero wraps out of range
	function automatic logic [`SFR_ADDR_W-1:0] row_of(
		input logic [`SFR_ADDR_W-1:0] a);
		return a - `SFR_ADDR_W'(1);
	endfunction : row_of
	// A one-clock fault pulse is enough; only reset clears the flag
	// sticky watchdog timeout, cleared only by reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wds_q <= 1'b0;
		end else if (clock_watchdog_fault) begin
			wds_q <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Bit counter and receive shifter
	// capture on falling SCK
	// MSB arrives first, shifts toward the top
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_q  <= 32'h00000000;
			cnt_q <= '0;
		end else if (cs_fall) begin
			cnt_q <= '0;
		end else if (sck_fall) begin
			rx_q <= {rx_q[30:0], pins_s.si};
			// saturate so overlong frames stay invalid
			if (cnt_q != CW'(`SFR_FRAME_BITS + 1))
				cnt_q <= cnt_q + CW'(1);
		end
	end
	assign cmd = sfr_cmd_t'(rx_q);
	////////////////////////////////////////////////////////////////////
	// Frame completion: validate, write, remember address
	// act only on exactly 32 bits
	// write loads data; read leaves store alone
	// writes to the identification address are dropped
	assign we = cs_rise && frame_whole(cnt_q) && cmd.rw &&
		cmd.addr != `SFR_ID_ADDR;
	// response chosen from the previous frame only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_q  <= `SFR_ID_ADDR;
			bad_q   <= 1'b0;
			first_q <= 1'b1;
		end else if (cs_rise) begin
			// A bad frame keeps the old address; the bad flag overrides it
			bad_q <= ~frame_whole(cnt_q);
			if (frame_whole(cnt_q))
				addr_q <= cmd.addr;
		end else if (cs_fall) begin
			// only the first frame after reset is forced
			first_q <= 1'b0;
		end
	end
	assign frame_error = bad_q;
	// address decode and store access
	// The write port borrows the address for one cycle at frame end; the
	// read data settle again well before the next frame may start
	assign mem_addr = we ? row_of(cmd.addr) : row_of(addr_q);
	sfr_regmem #(.DEPTH(DEPTH), .AW(`SFR_ADDR_W)) u_mem (
		.clk   (clk),
		.reset (reset),
		.we    (we),
		.addr  (mem_addr),
		.wdata (cmd.data),
		.rdata (mem_rdata)
	);
	// actual stored contents, rw bit zero
	// invalid frame returns identification
	// Priority: first frame, then bad frame, then the id address
	always_comb begin
		if (first_q || bad_q || addr_q == `SFR_ID_ADDR)
			resp = id_word(wds_q);
		else
			resp = {1'b0, addr_q, mem_rdata};
	end
	////////////////////////////////////////////////////////////////////
	// Transmit shifter
	// load at frame start, shift while receiving
	// The first rising SCK finds bit 31 already on SO, so it is skipped;
	// this keeps the master sampling on falling SCK for all 32 bits
	// SO advances on rising SCK; MSB first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_q <= 32'h00000000;
		end else if (cs_fall) begin
			tx_q <= resp;
		end else if (sck_rise && cnt_q != '0) begin
			tx_q <= {tx_q[30:0], 1'b0};
		end
	end
	// drive SO only inside a frame
	// Registered so the pad enable never glitches on a pin edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			so_oe <= 1'b0;
		end else begin
			so_oe <= ~pins_s.cs_n & ~cs_rise;
		end
	end
	assign so_out = tx_q[31];
	////////////////////////////////////////////////////////////////////
	// Checks on what this block drives; covers mark the main scenarios
	// quiet when deselected
	a_so_quiet: assert property (@(posedge clk)
		disable iff (reset) pins_s.cs_n && cs_q |=> !so_oe)
		else $error("SO driven outside frame");
	a_oe_frame: assert property (@(posedge clk)
		disable iff (reset) !pins_s.cs_n |=> so_oe)
		else $error("SO not driven inside frame");
	a_oe_release: assert property (@(posedge clk)
		disable iff (reset) cs_rise |=> !so_oe)
		else $error("SO still driven after frame end");
	a_cnt_clear: assert property (@(posedge clk)
		disable iff (reset) cs_fall |=> cnt_q == '0)
		else $error("bit count not cleared at frame start");
	a_cnt_sat: assert property (@(posedge clk)
		disable iff (reset) cnt_q <= CW'(`SFR_FRAME_BITS + 1))
		else $error("bit count ran past saturation");
	a_short_bad: assert property (@(posedge clk)
		disable iff (reset) cs_rise && cnt_q != CW'(32) |=> bad_q)
		else $error("bad frame not flagged");
	a_good_ok: assert property (@(posedge clk)
		disable iff (reset) cs_rise && cnt_q == CW'(32) |=>
		!bad_q && addr_q == $past(cmd.addr))
		else $error("good frame not taken");
	a_rx_capture: assert property (@(posedge clk)
		disable iff (reset) sck_fall && !cs_fall |=>
		rx_q[0] == $past(pins_s.si))
		else $error("SI not captured on falling SCK");
	a_tx_load: assert property (@(posedge clk)
		disable iff (reset) cs_fall |=> tx_q == $past(resp))
		else $error("response not loaded at frame start");
	// SO moves only at the frame-start load and on rising SCK
	a_tx_hold: assert property (@(posedge clk)
		disable iff (reset) !cs_fall && !sck_rise |=> $stable(tx_q))
		else $error("SO changed without rising SCK");
	a_tx_shift: assert property (@(posedge clk)
		disable iff (reset) sck_rise && cnt_q != '0 && !cs_fall |=>
		tx_q[31] == $past(tx_q[30]))
		else $error("SO not MSB-first shift");
	a_first_id: assert property (@(posedge clk)
		disable iff (reset) cs_fall && first_q |=>
		tx_q == id_word(wds_q))
		else $error("first frame not identification");
	a_bad_id: assert property (@(posedge clk)
		disable iff (reset) cs_fall && bad_q |=>
		tx_q == id_word(wds_q))
		else $error("invalid frame not answered with id");
	a_id_write: assert property (@(posedge clk)
		disable iff (reset) cs_rise && cmd.addr == `SFR_ID_ADDR |-> !we)
		else $error("identification address written");
	a_id_bit31: assert property (@(posedge clk)
		disable iff (reset) resp[31] == 1'b0)
		else $error("response bit 31 set");
	a_id_fields: assert property (@(posedge clk)
		disable iff (reset) addr_q == `SFR_ID_ADDR |->
		resp[23:8] == {MAKER, VERSION})
		else $error("id fields wrong");
	a_wds_set: assert property (@(posedge clk)
		disable iff (reset) clock_watchdog_fault |=> wds_q)
		else $error("watchdog status not set");
	a_wds_stick: assert property (@(posedge clk)
		disable iff (reset) wds_q |=> wds_q)
		else $error("watchdog status cleared");
	// Main scenarios: write, bad frame, data read, first frame, timeout
	c_write: cover property (@(posedge clk) disable iff (reset) we);
	c_bad: cover property (@(posedge clk) disable iff (reset)
		cs_rise && cnt_q != CW'(32));
	c_read: cover property (@(posedge clk) disable iff (reset)
		cs_fall && !first_q && !bad_q && addr_q != `SFR_ID_ADDR);
	c_first: cover property (@(posedge clk) disable iff (reset)
		cs_fall && first_q);
	c_wds: cover property (@(posedge clk) disable iff (reset) $rose(wds_q));
endmodule : sfr_responder

// ---- sfr_cfg.svh ----
// Constants of the serial frame responder: field positions, codes, timing.
// Assumes inclusion by bare name from package and modules.
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
`define SFR_FRAME_BITS     32
`define SFR_RW_BIT         31
`define SFR_ADDR_HI        30
`define SFR_ADDR_LO        24
`define SFR_ADDR_W         7
`define SFR_ID_ADDR        7'h00
`define SFR_MAKER_HI       23
`define SFR_MAKER_LO       16
`define SFR_VER_HI         15
`define SFR_VER_LO         8
`define SFR_WDS_BIT        1
`define SFR_MAKER_CODE     8'h5A
`define SFR_VER_CODE       8'h01
`define SFR_GAP_CYCLES     5
`define SFR_REG_DEPTH      4
`endif

// ---- sfr_pkg.sv ----
// Types of the serial frame responder.
// Assumes sfr_cfg.svh is on the include path.
`include "sfr_cfg.svh"
package sfr_pkg;
	// One command word split into its fields
	typedef struct packed {
		logic                    rw;
		logic [`SFR_ADDR_W-1:0] addr;
		logic [23:0]             data;
	} sfr_cmd_t;
	// Serial pin group toward the master
	typedef struct packed {
		logic sck;
		logic si;
		logic cs_n;
	} sfr_pins_t;
endpackage : sfr_pkg

// ---- sfr_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous inputs.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module sfr_sync #(
	parameter int           W    = 3,
	parameter logic [W-1:0] INIT = '1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	// First stage only feeds second stage; reset to the pins' idle levels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sfr_sync

// ---- sfr_regmem.sv ----
// Small register store addressed by row (command address minus one); read data registered.
// Assumes one write or read per frame, well below clock rate.
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module sfr_regmem #(
	parameter int DEPTH = `SFR_REG_DEPTH,
	parameter int AW    = `SFR_ADDR_W
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [23:0]   wdata,
	output logic      [23:0]   rdata
);
	logic [23:0] mem_q [DEPTH];
	// Writes land only on mapped rows; others are dropped
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= 24'h000000;
		end else if (we && addr < AW'(DEPTH)) begin
			mem_q[addr[$clog2(DEPTH)-1:0]] <= wdata;
		end
	end
	// Unmapped rows read zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 24'h000000;
		end else if (addr < AW'(DEPTH)) begin
			rdata <= mem_q[addr[$clog2(DEPTH)-1:0]];
		end else begin
			rdata <= 24'h000000;
		end
	end
endmodule : sfr_regmem

// ---- sfr_master_model.sv ----
// SPI master model that drives frames toward the frame responder.
// Assumes the bench resolves the SO wire from so_out and so_oe.
`timescale 1ns/1ps
module sfr_master_model (
	output logic     sck,
	output logic     si,
	output logic     chip_select_n,
	input  wire logic so
);
	////////////////////////////////////////////////////////////////////
	// Idle: clock low and still between frames, select high
	initial begin
		sck <= 1'b0;
		si <= 1'b0;
		chip_select_n <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	// frame bounds, lead, lag and gap
	// SI set at rise, SO taken at fall, MSB first
	task automatic xfer(input logic [39:0] w, input int n,
		output logic [39:0] rx);
		rx = '0;
		chip_select_n <= 1'b0;
		#250;
		for (int i = n - 1; i >= 0; i--) begin
			sck <= 1'b1;
			si <= w[i];
			#32;
			sck <= 1'b0;
			rx = {rx[38:0], so};
			#32;
		end
		#250;
		chip_select_n <= 1'b1;
		si <= ~si; // Released line must not hold its last value
		#100; // Gap well above five clocks
	endtask : xfer
endmodule : sfr_master_model

// ---- spi_frame_responder_id_reg_tb.sv ----
// Self-checking bench for the serial frame responder.
// Assumes the master model and default design parameters.
`timescale 1ns/1ps
`include "sfr_cfg.svh"
module spi_frame_responder_id_reg_tb;
	import sfr_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        clock_watchdog_fault = 1'b0;
	logic        so_last = 1'b0;
	logic [31:0] prev;
	logic        prev_ok;
	logic        clock_watchdog_status;
	logic [31:0] lfsr;
	logic [23:0] mem [4];
	int          failures;
	int          n_compared;
	wire         sck;
	wire         si;
	wire         chip_select_n;
	wire         so_out;
	wire         so_oe;
	wire         frame_error;
	wire         so = so_oe ? so_out : ~so_last;
	////////////////////////////////////////////////////////////////////
	// Clock and last driven SO level, inverted when released
	always #2.5 clk = ~clk;
	always @(posedge clk) if (so_oe) so_last <= so_out;
	sfr_responder sfr_responder_inst (
		.clk(clk), .reset(reset), .sck(sck), .si(si),
		.chip_select_n(chip_select_n),
		.clock_watchdog_fault(clock_watchdog_fault),
		.so_out(so_out), .so_oe(so_oe), .frame_error(frame_error));
	sfr_master_model sfr_master_model_inst (
		.sck(sck), .si(si), .chip_select_n(chip_select_n), .so(so));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	function automatic logic [31:0] exp_resp();
		logic [6:0] a;
		a = prev[30:24];
		if (!prev_ok || a == 7'h00)
			return {8'h00, 8'(`SFR_MAKER_CODE), 8'(`SFR_VER_CODE),
				6'h00, clock_watchdog_status, 1'b0};
		if (a >= 7'h01 && a <= 7'h04)
			return {1'b0, a, mem[a - 7'h01]};
		return {1'b0, a, 24'h000000};
	endfunction : exp_resp
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	// One frame of n bits; compares response (32-bit frames only), error flag and release
	task automatic frame(input logic [39:0] w, input int n);
		logic [39:0] rx;
		logic [31:0] e;
		e = exp_resp();
		sfr_master_model_inst.xfer(w, n, rx);
		if (n == 32) check("response", e, rx[31:0]);
		check("frame_error", 32'(n != 32), 32'(frame_error));
		check("so_oe", 32'h0, 32'(so_oe));
		// only whole writes to data rows change state
		if (n == 32 && w[31] && w[30:24] >= 1 && w[30:24] <= 4)
			mem[w[30:24] - 1] = w[23:0];
		prev = w[31:0];
		prev_ok = (n == 32);
	endtask : frame
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		prev_ok = 1'b0;
		clock_watchdog_status = 1'b0;
		foreach (mem[i]) mem[i] = 24'h000000;
		repeat (5) @(posedge clk);
	endtask : do_reset
	task automatic complete_run();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////
	// Main sequence: random traffic, then corner cases
	initial begin
		failures = 0;
		n_compared = 0;
		lfsr = 32'hDB8A;
		prev = '0;
		do_reset();
		frame({8'h00, 32'h81ABCDEF}, 32);
		for (int i = 0; i < 40; i++) begin
			lfsr = lfsr_next(lfsr);
			frame({8'h00, lfsr & 32'h87FFFFFF}, 32);
		end
		frame({8'h00, 32'h8200FFFF}, 32);
		frame({8'h00, 32'h02123456}, 32);
		frame({8'h00, 32'h80FFFFFF}, 32);
		frame({8'h00, 32'h02000000}, 32);
		frame({8'h00, 32'h83111111}, 31);
		frame({8'h00, 32'h02000000}, 32);
		frame({8'h01, 32'h03000000}, 33);
		frame({8'h00, 32'h02000000}, 32);
		@(posedge clk) clock_watchdog_fault <= 1'b1;
		@(posedge clk) clock_watchdog_fault <= 1'b0;
		clock_watchdog_status = 1'b1;
		frame({8'h00, 32'h00000000}, 32);
		frame({8'h00, 32'h00000000}, 32);
		frame({8'h00, 32'h00000000}, 32);
		do_reset();
		frame({8'h00, 32'h82C0FFEE}, 32);
		frame({8'h00, 32'h02000000}, 32);
		frame({8'h00, 32'h00000000}, 32);
		complete_run();
	end
	// Watchdog at twice the expected run of about 150 us (30k clocks)
	initial begin
		#300000;
		failures++;
		complete_run();
	end
endmodule : spi_frame_responder_id_reg_tb
